// File: rtl/gcr_command_map.sv
// Command register map of the fuel gauge with standby and peak load tracking
`timescale 1ns/10ps
`include "gcr_defs.svh"

// Overview of operation
// - Standby word reads initial, then measured estimate
// - Estimate refreshed per second within current window
// - First and last qualifying samples are skipped
// - New estimate is fifteen sixteenths old plus sixteenth
// - Standby time left reads all ones idle
// - Peak load starts initial, grows with measurement
// - Full after deep discharge halves toward initial
// - Peak load time left all ones idle
// - Average power reads zero when idle
// - Constant power time per second, ones at zero
// - Health percentage clamped to one hundred
// - Health code holds four defined values only
// - Charge percentage clamped to one hundred
// - Impedance word is read only, milliohms
// - Instant current latched once per second
// - Extended commands are one or many bytes
// - Locked mode refuses class selector entirely
// - Open general mode block selects 32-byte block
// - Locked block selects auth, info A, info B
// - Design capacity readable in both modes
// - Control byte zero selects general flash access in open mode
// - Flash commit only after correct checksum
module gcr_command_map
    import gcr_pkg::*;
#(
    parameter int TickCycles = `GCR_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Security mode from the control word decoder
    input  wire logic        lockedMode,
    // Gauging core values
    input  wire gcr_meas_t   meas,
    // Command port
    input  wire gcr_cmd_t    cmd,
    output gcr_state_t       dummyUnused_q,
    output logic [7:0]       rdData_q,
    // Flash commit request and block contents
    output gcr_commit_t      commit_q,
    output logic [31:0][7:0] winData_q
);

    gcr_state_t st_q;
    gcr_state_t st_d;

    // Byte of a word, low byte at even code
    function automatic logic [7:0] wordByte(input logic [15:0] w, input logic hi);
        return hi ? w[15:8] : w[7:0];
    endfunction

    // Address range test
    function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic signed [15:0] disCur;
    logic signed [15:0] stbyOut;
    logic signed [15:0] peakOut;
    logic               qualify;
    logic [7:0]         hlthPct;
    logic [15:0]        chargeCl;
    logic               generalMode;
    logic               winWritable;

    // Discharge magnitude and visible adaptive words
    always_comb begin
        disCur      = -meas.avgCurrent;
        stbyOut     = st_q.stbyValid ? st_q.stbyEst : meas.initStandby;
        peakOut     = st_q.peakValid ? st_q.peak : meas.initMaxLoad;
        qualify     = (17'(disCur) > 17'(meas.deadband))
                      && (17'(disCur) <= {meas.initStandby, 1'b0});
        hlthPct     = (meas.healthPct > `GCR_HLTH_MAX) ? `GCR_HLTH_MAX
                      : meas.healthPct;
        chargeCl    = (meas.charge > `GCR_CHARGE_MAX) ? `GCR_CHARGE_MAX
                      : meas.charge;
        generalMode = !lockedMode && (st_q.ctl == `GCR_CTL_GENERAL);
        winWritable = !lockedMode
                      || (st_q.blk == `GCR_BLK_AUTH)
                      || (st_q.blk == `GCR_BLK_INFO_B);
    end

    // Next state of the whole map
    always_comb begin
        logic [7:0]  sum;
        logic [2:0]  nameIdx;
        logic [7:0]  rb;
        logic        hi;
        sum     = 8'h00;
        nameIdx = 3'(cmd.addr - `GCR_CMD_NAME_FIRST);
        rb      = 8'h00;
        hi      = cmd.addr[0];
        st_d    = st_q;
        st_d.commit.valid = 1'b0;
        for (int i = 0; i < 32; i++) begin
            sum = sum + st_q.win[i];
        end
        // One second tick
        st_d.tickHit = 1'b0;
        if (st_q.tick == 27'(TickCycles - 1)) begin
            st_d.tick    = 27'h0;
            st_d.tickHit = 1'b1;
        end else begin
            st_d.tick = st_q.tick + 27'h1;
        end
        // Remember a discharge below half charge
        if (meas.discharging && (meas.charge < `GCR_LOW_CHARGE)) begin
            st_d.lowSeen = 1'b1;
        end
        // Per second measurement updates
        if (st_q.tickHit) begin
            if (qualify) begin
                // Pending sample is neither first nor last of the run
                if (st_q.runLen == 2'd2) begin
                    st_d.stbyEst = stbyOut - (stbyOut >>> `GCR_FILTER_SHIFT)
                                   + (st_q.pend >>> `GCR_FILTER_SHIFT);
                    st_d.stbyValid = 1'b1;
                end
                st_d.pend = disCur;
                if (st_q.runLen != 2'd2) begin
                    st_d.runLen = st_q.runLen + 2'd1;
                end
            end else begin
                st_d.runLen = 2'd0;
            end
            st_d.stbyTte = meas.discharging ? meas.standbyTte
                           : `GCR_NO_DISCHARGE;
            st_d.peakTte = meas.discharging ? meas.peakTte
                           : `GCR_NO_DISCHARGE;
            st_d.power   = meas.discharging ? meas.power : 16'sh0000;
            st_d.cpTte   = (meas.discharging && (meas.power != 16'sh0000))
                           ? meas.cpTte : `GCR_NO_DISCHARGE;
            st_d.instCur = meas.instCurrent;
            if (meas.fullCharge && st_q.lowSeen) begin
                st_d.peak      = 16'((17'(peakOut) + 17'(meas.initMaxLoad)) >>> 1);
                st_d.peakValid = 1'b1;
                st_d.lowSeen   = 1'b0;
            end else if (disCur > peakOut) begin
                st_d.peak      = disCur;
                st_d.peakValid = 1'b1;
            end
        end
        // Command writes
        if (cmd.wr) begin
            if (cmd.addr == `GCR_CMD_CLASS && !lockedMode) begin
                st_d.cls = cmd.data;
            end
            if (cmd.addr == `GCR_CMD_BLOCK) begin
                st_d.blk = cmd.data;
            end
            if (cmd.addr == `GCR_CMD_BLK_CTL && !lockedMode) begin
                st_d.ctl = cmd.data;
            end
            if (inRange(cmd.addr, `GCR_CMD_WIN_FIRST, `GCR_CMD_WIN_LAST)
                && winWritable) begin
                st_d.win[cmd.addr[4:0]] = cmd.data;
            end
            if (cmd.addr == `GCR_CMD_CHECKSUM) begin
                st_d.cks = cmd.data;
                if ((8'hFF - sum) == cmd.data && winWritable) begin
                    st_d.commit.valid   = 1'b1;
                    st_d.commit.general = generalMode;
                    st_d.commit.cls     = generalMode ? st_q.cls : 8'h00;
                    st_d.commit.blk     = st_q.blk;
                end
            end
        end
        // Read mux, words little endian
        if (cmd.rd) begin
            if (inRange(cmd.addr, `GCR_CMD_WIN_FIRST, `GCR_CMD_WIN_LAST)) begin
                rb = st_q.win[cmd.addr[4:0]];
            end else if (inRange(cmd.addr, `GCR_CMD_NAME_FIRST,
                                 `GCR_CMD_NAME_LAST)) begin
                rb = meas.nameStr[8*nameIdx +: 8];
            end else begin
                unique case ({cmd.addr[7:1], 1'b0})
                    `GCR_CMD_STBY_CUR:  rb = wordByte(stbyOut, hi);
                    `GCR_CMD_STBY_TTE:  rb = wordByte(st_q.stbyTte, hi);
                    `GCR_CMD_PEAK_CUR:  rb = wordByte(peakOut, hi);
                    `GCR_CMD_PEAK_TTE:  rb = wordByte(st_q.peakTte, hi);
                    `GCR_CMD_POWER:     rb = wordByte(st_q.power, hi);
                    `GCR_CMD_CP_TTE:    rb = wordByte(st_q.cpTte, hi);
                    `GCR_CMD_HLTH_PCT:  rb = hi ? {6'h00, meas.healthCode}
                                             : hlthPct;
                    `GCR_CMD_CHARGE:    rb = wordByte(chargeCl, hi);
                    `GCR_CMD_IMPEDANCE: rb = wordByte(meas.impedance, hi);
                    `GCR_CMD_INST_CUR:  rb = wordByte(st_q.instCur, hi);
                    `GCR_CMD_DESIGN_CAPACITY:      rb = wordByte(meas.designCap, hi);
                    `GCR_CMD_CLASS:     rb = hi ? st_q.blk
                                             : (lockedMode ? 8'h00 : st_q.cls);
                    `GCR_CMD_CHECKSUM:  rb = hi ? (lockedMode ? 8'h00 : st_q.ctl)
                                             : st_q.cks;
                    `GCR_CMD_NAME_LEN:  rb = hi ? 8'h00 : meas.nameLen;
                    `GCR_CMD_APP_STATE: rb = hi ? 8'h00 : meas.appState;
                    default:            rb = 8'h00;
                endcase
            end
            st_d.rdData = rb;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q           <= '0;
            st_q.stbyTte   <= `GCR_NO_DISCHARGE;
            st_q.peakTte   <= `GCR_NO_DISCHARGE;
            st_q.cpTte     <= `GCR_NO_DISCHARGE;
            st_q.cls       <= `GCR_CLASS_RST;
            st_q.blk       <= `GCR_BLOCK_RST;
            st_q.ctl       <= `GCR_CTL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign dummyUnused_q = st_q;
    assign rdData_q      = st_q.rdData;
    assign commit_q      = st_q.commit;
    assign winData_q     = st_q.win;

    // Helper sum of the window for the commit check
    logic [7:0] sum_w;
    always_comb begin
        sum_w = 8'h00;
        for (int i = 0; i < 32; i++) begin
            sum_w = sum_w + st_q.win[i];
        end
    end

    // Checks
    property p_stby_initial;
        @(posedge ref_clk) disable iff (rst)
        cmd.rd && (cmd.addr == `GCR_CMD_STBY_CUR) && !st_q.stbyValid
        |=> rdData_q == $past(meas.initStandby[7:0]);
    endproperty
    a_stby_initial: assert property (p_stby_initial)
        else $error("standby word not initial value");

    property p_stby_on_tick;
        @(posedge ref_clk) disable iff (rst)
        $changed(st_q.stbyEst) |-> $past(st_q.tickHit) && $past(qualify);
    endproperty
    a_stby_on_tick: assert property (p_stby_on_tick)
        else $error("standby estimate changed off tick");

    property p_skip_first;
        @(posedge ref_clk) disable iff (rst)
        st_q.tickHit && (st_q.runLen != 2'd2) |=> $stable(st_q.stbyEst);
    endproperty
    a_skip_first: assert property (p_skip_first)
        else $error("early sample averaged in");

    property p_stby_tte_idle;
        @(posedge ref_clk) disable iff (rst)
        st_q.tickHit && !meas.discharging |=> st_q.stbyTte == 16'hFFFF;
    endproperty
    a_stby_tte_idle: assert property (p_stby_tte_idle)
        else $error("standby time not all ones when idle");

    property p_peak_grow;
        @(posedge ref_clk) disable iff (rst)
        st_q.tickHit && !(meas.fullCharge && st_q.lowSeen) && (disCur > peakOut)
        |=> st_q.peak == $past(disCur);
    endproperty
    a_peak_grow: assert property (p_peak_grow)
        else $error("peak load not updated");

    property p_cp_zero;
        @(posedge ref_clk) disable iff (rst)
        st_q.power == 16'sh0000 |-> st_q.cpTte == 16'hFFFF;
    endproperty
    a_cp_zero: assert property (p_cp_zero)
        else $error("constant power time wrong at zero power");

    property p_hlth_clamp;
        @(posedge ref_clk) disable iff (rst)
        cmd.rd && (cmd.addr == `GCR_CMD_HLTH_PCT) |=> rdData_q <= 8'h64;
    endproperty
    a_hlth_clamp: assert property (p_hlth_clamp)
        else $error("health percent above limit");

    property p_class_locked;
        @(posedge ref_clk) disable iff (rst)
        lockedMode && cmd.wr && (cmd.addr == `GCR_CMD_CLASS) |=> $stable(st_q.cls);
    endproperty
    a_class_locked: assert property (p_class_locked)
        else $error("class written in locked mode");

    property p_commit_cause;
        @(posedge ref_clk) disable iff (rst)
        commit_q.valid |-> $past(cmd.wr) && ($past(cmd.addr) == `GCR_CMD_CHECKSUM)
                           && ($past(cmd.data) == 8'hFF - $past(sum_w));
    endproperty
    a_commit_cause: assert property (p_commit_cause)
        else $error("commit without correct checksum");

    property p_word_order;
        @(posedge ref_clk) disable iff (rst)
        cmd.rd && (cmd.addr == 8'h3D) |=> rdData_q == $past(meas.designCap[15:8]);
    endproperty
    a_word_order: assert property (p_word_order)
        else $error("high byte not at odd code");

    property p_hlth_code;
        @(posedge ref_clk) disable iff (rst)
        cmd.rd && (cmd.addr == `GCR_CMD_HLTH_CODE) |=> rdData_q <= 8'h03;
    endproperty
    a_hlth_code: assert property (p_hlth_code)
        else $error("health code outside defined values");

    property p_inst_on_tick;
        @(posedge ref_clk) disable iff (rst)
        $changed(st_q.instCur) |-> $past(st_q.tickHit);
    endproperty
    a_inst_on_tick: assert property (p_inst_on_tick)
        else $error("instant current changed off tick");

    property p_halve_clears;
        @(posedge ref_clk) disable iff (rst)
        st_q.tickHit && meas.fullCharge && st_q.lowSeen
        |=> st_q.peakValid && !st_q.lowSeen;
    endproperty
    a_halve_clears: assert property (p_halve_clears)
        else $error("deep discharge mark not cleared at full");

    property p_info_a_locked;
        @(posedge ref_clk) disable iff (rst)
        lockedMode && (st_q.blk == `GCR_BLK_INFO_A) && cmd.wr
        |=> !commit_q.valid && $stable(st_q.win);
    endproperty
    a_info_a_locked: assert property (p_info_a_locked)
        else $error("information block A altered in locked mode");

    c_commit: cover property (@(posedge ref_clk) commit_q.valid);
    c_adapted: cover property (@(posedge ref_clk) $rose(st_q.stbyValid));
    c_halved: cover property (@(posedge ref_clk) st_q.tickHit && meas.fullCharge
                              && st_q.lowSeen);

endmodule // gcr_command_map

// File: inc/gcr_defs.svh
// Command codes, field values and timing counts of the gauge command map
`ifndef GCR_DEFS_SVH
`define GCR_DEFS_SVH
`define GCR_CMD_STBY_CUR   8'h1A
`define GCR_CMD_STBY_TTE   8'h1C
`define GCR_CMD_PEAK_CUR   8'h1E
`define GCR_CMD_PEAK_TTE   8'h20
`define GCR_CMD_POWER      8'h24
`define GCR_CMD_CP_TTE     8'h26
`define GCR_CMD_HLTH_PCT   8'h28
`define GCR_CMD_HLTH_CODE  8'h29
`define GCR_CMD_CHARGE     8'h2C
`define GCR_CMD_IMPEDANCE  8'h2E
`define GCR_CMD_INST_CUR   8'h30
`define GCR_CMD_DESIGN_CAPACITY       8'h3C
`define GCR_CMD_CLASS      8'h3E
`define GCR_CMD_BLOCK      8'h3F
`define GCR_CMD_WIN_FIRST  8'h40
`define GCR_CMD_WIN_LAST   8'h5F
`define GCR_CMD_CHECKSUM   8'h60
`define GCR_CMD_BLK_CTL    8'h61
`define GCR_CMD_NAME_LEN   8'h62
`define GCR_CMD_NAME_FIRST 8'h63
`define GCR_CMD_NAME_LAST  8'h69
`define GCR_CMD_APP_STATE  8'h6A
`define GCR_NO_DISCHARGE   16'hFFFF
`define GCR_HLTH_MAX       8'h64
`define GCR_CHARGE_MAX     16'h0064
`define GCR_LOW_CHARGE     16'h0032
`define GCR_CTL_GENERAL    8'h00
`define GCR_BLK_AUTH       8'h00
`define GCR_BLK_INFO_A     8'h01
`define GCR_BLK_INFO_B     8'h02
`define GCR_CLASS_RST      8'h00
`define GCR_BLOCK_RST      8'h00
`define GCR_CTL_RST        8'h00
`define GCR_FILTER_SHIFT   4
`define GCR_TICK_MS        1000
`define GCR_CLK_KHZ        100000
`define GCR_TICK_CYCLES    (`GCR_TICK_MS * `GCR_CLK_KHZ)
`endif

// File: inc/gcr_pkg.sv
// Types shared by the gauge command map
package gcr_pkg;
    // Measurements and stored values handed over by the gauging core
    typedef struct packed {
        logic signed [15:0] avgCurrent;
        logic signed [15:0] instCurrent;
        logic signed [15:0] deadband;
        logic signed [15:0] initStandby;
        logic signed [15:0] initMaxLoad;
        logic        [15:0] standbyTte;
        logic        [15:0] peakTte;
        logic signed [15:0] power;
        logic        [15:0] cpTte;
        logic        [7:0]  healthPct;
        logic        [1:0]  healthCode;
        logic        [15:0] charge;
        logic        [15:0] impedance;
        logic        [15:0] designCap;
        logic        [7:0]  nameLen;
        logic        [55:0] nameStr;
        logic        [7:0]  appState;
        logic               discharging;
        logic               fullCharge;
    } gcr_meas_t;
    // One byte access to a command code
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } gcr_cmd_t;
    // Request to store the block window into flash
    typedef struct packed {
        logic       valid;
        logic       general;
        logic [7:0] cls;
        logic [7:0] blk;
    } gcr_commit_t;
    // Whole state of the command map
    typedef struct packed {
        logic [26:0]        tick;
        logic               tickHit;
        logic signed [15:0] stbyEst;
        logic               stbyValid;
        logic [1:0]         runLen;
        logic signed [15:0] pend;
        logic [15:0]        stbyTte;
        logic signed [15:0] peak;
        logic               peakValid;
        logic               lowSeen;
        logic [15:0]        peakTte;
        logic signed [15:0] power;
        logic [15:0]        cpTte;
        logic signed [15:0] instCur;
        logic [7:0]         cls;
        logic [7:0]         blk;
        logic [7:0]         ctl;
        logic [7:0]         cks;
        logic [31:0][7:0]   win;
        logic [7:0]         rdData;
        gcr_commit_t        commit;
    } gcr_state_t;
endpackage

// File: test/gcr_host_model.sv
// Host controller model issuing byte commands to the command map
`timescale 1ns/10ps
module gcr_host_model
    import gcr_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Command port toward the map
    output gcr_cmd_t        cmd,
    input  wire logic [7:0] rdData_q
);
    initial cmd = '0;

    // One write strobe; idle fields then show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        cmd = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge ref_clk);
        #1;
        cmd = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    // One read strobe, byte taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        cmd = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge ref_clk);
        #1;
        d = rdData_q;
        cmd = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hFF};
    endtask

    // Whole window then its complemented sum, spoilt on request
    task automatic send_block(input logic [31:0][7:0] blk, input logic bad);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 32; i++) begin
            wr(8'h40 + 8'(i), blk[i]);
            sum = sum + blk[i];
        end
        wr(8'h60, 8'hFF - sum + {7'h00, bad});
    endtask
endmodule // gcr_host_model

// File: test/tb_gauge_command_map.sv
// Self-checking bench of the gauge command map
`timescale 1ns/10ps
module tb_gauge_command_map;
    import gcr_pkg::*;
    localparam int Tick = 10;
    logic             ref_clk = 1'b0;
    logic             rst = 1'b1;
    logic             lockedMode = 1'b0;
    gcr_meas_t        meas = '0;
    gcr_cmd_t         cmd;
    logic [7:0]       rdData_q;
    gcr_commit_t      commit_q;
    logic [31:0][7:0] winData_q;
    gcr_state_t       dbg;
    int               errors = 0;
    int               total_checks = 0;
    int               commits = 0;
    int               seen;
    gcr_commit_t      lastCommit = '0;
    logic [15:0]      w;
    logic [15:0]      v;
    logic [7:0]       b;
    logic [7:0]       cls;
    logic [7:0]       blkNo;
    logic [31:0][7:0] blk;
    int               k;

    // Clock
    always #5 ref_clk = ~ref_clk;

    gcr_command_map #(.TickCycles(Tick)) u_dut (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .lockedMode    (lockedMode),
        .meas          (meas),
        .cmd           (cmd),
        .dummyUnused_q (dbg),
        .rdData_q      (rdData_q),
        .commit_q      (commit_q),
        .winData_q     (winData_q)
    );

    gcr_host_model u_host (
        .ref_clk  (ref_clk),
        .cmd      (cmd),
        .rdData_q (rdData_q)
    );

    // Commit pulse monitor
    always @(posedge ref_clk) begin
        if (commit_q.valid === 1'b1) begin
            commits <= commits + 1;
            lastCommit <= commit_q;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdw(input logic [7:0] a, output logic [15:0] d);
        logic [7:0] lo;
        logic [7:0] hi;
        u_host.rd(a, lo);
        u_host.rd(a + 8'h01, hi);
        d = {hi, lo};
    endtask

    task automatic ticks(input int n);
        repeat (n * Tick) @(posedge ref_clk);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [15:0] clampPct(input logic [15:0] x);
        return (x > 16'h0064) ? 16'h0064 : x;
    endfunction

    // Watchdog
    initial begin
        #300000;
        errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(15));
        meas.initStandby = 16'h0014;
        meas.deadband = 16'h0005;
        meas.initMaxLoad = 16'h03E8;
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        // Idle words after reset
        rdw(8'h1C, w);
        chk(w, 16'hFFFF);
        rdw(8'h20, w);
        chk(w, 16'hFFFF);
        rdw(8'h24, w);
        chk(w, 16'h0000);
        rdw(8'h26, w);
        chk(w, 16'hFFFF);
        rdw(8'h1A, w);
        chk(w, 16'h0014);
        rdw(8'h1E, w);
        chk(w, 16'h03E8);
        u_host.rd(8'h34, b);
        chk({8'h00, b}, 16'h0000);
        $display("test reset done");
        // Single qualifying sample is never averaged
        meas.avgCurrent = 16'hFFE0;
        repeat (Tick) @(posedge ref_clk);
        #1;
        meas.avgCurrent = 16'hFFCE;
        ticks(3);
        rdw(8'h1A, w);
        chk(w, 16'h0014);
        // Long qualifying run pulls the estimate toward the sample
        meas.avgCurrent = 16'hFFE0;
        ticks(12);
        rdw(8'h1A, w);
        chk(16'(w > 16'h0014 && w <= 16'h0020), 16'h0001);
        meas.avgCurrent = 16'hFFCE;
        ticks(2);
        rdw(8'h1A, w);
        ticks(3);
        rdw(8'h1A, v);
        chk(v, w);
        $display("test standby done");
        // Peak growth, deep discharge, then full charge
        meas.avgCurrent = 16'hFA24;
        ticks(2);
        rdw(8'h1E, w);
        chk(w, 16'h05DC);
        meas.avgCurrent = 16'h0000;
        meas.discharging = 1'b1;
        meas.charge = 16'h001E;
        meas.standbyTte = 16'($urandom_range(0, 65534));
        meas.peakTte = 16'($urandom_range(0, 65534));
        meas.cpTte = 16'($urandom_range(0, 65534));
        meas.power = 16'($urandom_range(1, 32767));
        ticks(2);
        rdw(8'h1C, w);
        chk(w, meas.standbyTte);
        rdw(8'h20, w);
        chk(w, meas.peakTte);
        rdw(8'h24, w);
        chk(w, meas.power);
        rdw(8'h26, w);
        chk(w, meas.cpTte);
        meas.power = 16'h0000;
        ticks(2);
        rdw(8'h26, w);
        chk(w, 16'hFFFF);
        meas.discharging = 1'b0;
        meas.charge = 16'h0064;
        meas.fullCharge = 1'b1;
        repeat (Tick) @(posedge ref_clk);
        #1;
        meas.fullCharge = 1'b0;
        ticks(2);
        rdw(8'h1E, w);
        chk(w, 16'h04E2);
        rdw(8'h24, w);
        chk(w, 16'h0000);
        $display("test peak done");
        // Random measurement words in both modes
        for (int i = 0; i < 8; i++) begin
            lockedMode = i[0]; // mode stands in for the control word decoder
            meas.healthPct = 8'($urandom);
            meas.healthCode = 2'($urandom);
            meas.charge = 16'($urandom_range(0, 255));
            meas.impedance = 16'($urandom);
            meas.instCurrent = 16'($urandom);
            meas.designCap = 16'($urandom);
            meas.nameStr = 56'({$urandom, $urandom});
            meas.appState = 8'($urandom);
            meas.nameLen = 8'($urandom);
            k = $urandom_range(0, 6);
            ticks(2);
            u_host.rd(8'h28, b);
            chk({8'h00, b}, clampPct({8'h00, meas.healthPct}));
            u_host.rd(8'h29, b);
            chk({8'h00, b}, {14'h0000, meas.healthCode});
            rdw(8'h2C, w);
            chk(w, clampPct(meas.charge));
            rdw(8'h2E, w);
            chk(w, meas.impedance);
            rdw(8'h30, w);
            chk(w, meas.instCurrent);
            rdw(8'h3C, w);
            chk(w, meas.designCap);
            u_host.rd(8'h62, b);
            chk({8'h00, b}, {8'h00, meas.nameLen});
            u_host.rd(8'h63 + 8'(k), b);
            chk({8'h00, b}, {8'h00, meas.nameStr[8*k +: 8]});
            u_host.rd(8'h6A, b);
            chk({8'h00, b}, {8'h00, meas.appState});
        end
        $display("test words done");
        // Open mode general flash block
        lockedMode = 1'b0;
        cls = 8'($urandom);
        blkNo = 8'($urandom_range(0, 7));
        u_host.wr(8'h61, 8'h00);
        u_host.wr(8'h3E, cls);
        u_host.wr(8'h3F, blkNo);
        u_host.rd(8'h3E, b);
        chk({8'h00, b}, {8'h00, cls});
        u_host.rd(8'h3F, b);
        chk({8'h00, b}, {8'h00, blkNo});
        chk({8'h00, dbg.blk}, {8'h00, blkNo});
        for (int i = 0; i < 32; i++) blk[i] = 8'($urandom);
        seen = commits;
        u_host.send_block(blk, 1'b1);
        ticks(1);
        chk(16'(commits), 16'(seen));
        for (int i = 0; i < 32; i++) chk({8'h00, winData_q[i]}, {8'h00, blk[i]});
        u_host.send_block(blk, 1'b0);
        ticks(1);
        chk(16'(commits), 16'(seen + 1));
        chk({lastCommit.cls, lastCommit.blk}, {cls, blkNo});
        chk({15'h0000, lastCommit.general}, 16'h0001);
        $display("test open flash done");
        // Locked mode selectors and information blocks
        lockedMode = 1'b1;
        u_host.wr(8'h3E, 8'h55);
        u_host.rd(8'h3E, b);
        chk({8'h00, b}, 16'h0000);
        u_host.rd(8'h61, b);
        chk({8'h00, b}, 16'h0000);
        u_host.wr(8'h3F, 8'h02);
        u_host.send_block(~blk, 1'b0);
        ticks(1);
        chk(16'(commits), 16'(seen + 2));
        chk({7'h00, lastCommit.general, lastCommit.blk}, 16'h0002);
        u_host.wr(8'h3F, 8'h01);
        u_host.send_block(blk, 1'b0);
        ticks(1);
        chk(16'(commits), 16'(seen + 2));
        chk({8'h00, winData_q[5]}, {8'h00, ~blk[5]});
        u_host.wr(8'h3F, 8'h00);
        u_host.rd(8'h3F, b);
        chk({8'h00, b}, 16'h0000);
        $display("test locked flash done");
        wrap_up();
    end
endmodule // tb_gauge_command_map
